/* File: hdl/mrb_defines.svh */
`ifndef MRB_DEFINES_SVH
`define MRB_DEFINES_SVH

// ----------------------------------------
// Mode register addresses and commands
// ----------------------------------------
`define MRB_ADDR_INFO     8'h00
`define MRB_ADDR_FEAT     8'h01
`define MRB_ADDR_CAL      8'h0A
`define MRB_CAL_INIT      8'hFF

// ----------------------------------------
// Feature register fields
// ----------------------------------------
`define MRB_BL_LSB        0
`define MRB_BT_BIT        3
`define MRB_WC_BIT        4
`define MRB_WR_LSB        5
`define MRB_BL4           3'h2
`define MRB_BL8           3'h3
`define MRB_BL16          3'h4
`define MRB_WR_MIN        3'h1
`define MRB_WR_MAX        3'h6
`define MRB_WR_BIAS       4'h2
`define MRB_BL_RST        3'h2
`define MRB_WR_RST        3'h1

// ----------------------------------------
// Information register fields
// ----------------------------------------
`define MRB_ST_LSB        3
`define MRB_ST_NOT_RUN    2'h0
`define MRB_ST_SUPPLY     2'h1
`define MRB_ST_GROUND     2'h2
`define MRB_ST_PASS       2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define MRB_CAL_CYCLES    4'h4
`define MRB_TCK_PS        4000
`define MRB_TWR_PS        15000
`define MRB_WR_CODE       (((`MRB_TWR_PS + `MRB_TCK_PS - 1) / `MRB_TCK_PS) - 2)

// ----------------------------------------
// Controller APB map
// ----------------------------------------
`define MRB_APB_CMD       12'h000
`define MRB_APB_STATUS    12'h004
`define MRB_APB_BURST     12'h008

`endif

/* File: hdl/mrb_pkg.sv */
package mrb_pkg;
    typedef enum logic [1:0] {
        DEV_IDLE,
        DEV_BURST,
        DEV_RECOVER
    } mrb_dev_st_t;

    typedef enum logic [1:0] {
        CTL_IDLE,
        CTL_WAIT_READ
    } mrb_ctl_st_t;
endpackage

/* File: hdl/mrb_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mrb_link_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic       mr_valid;
    logic       mr_write;
    logic [7:0] mr_addr;
    logic [7:0] mr_wdata;
    logic       mr_rvalid;
    logic [7:0] mr_rdata;
    logic       bst_start;
    logic [3:0] bst_col;
    logic       bst_write_ap;
    logic       bst_busy;
    logic       beat_valid;
    logic [3:0] beat_col;

    modport device (
        input  pclk, presetn, mr_valid, mr_write, mr_addr, mr_wdata,
               bst_start, bst_col, bst_write_ap,
        output mr_rvalid, mr_rdata, bst_busy, beat_valid, beat_col
    );
    modport controller (
        input  pclk, presetn, mr_rvalid, mr_rdata, bst_busy, beat_valid, beat_col,
        output mr_valid, mr_write, mr_addr, mr_wdata, bst_start, bst_col, bst_write_ap
    );
endinterface // mrb_link_if
`default_nettype wire

/* File: hdl/mrb_device.sv */
// Overview of operation
// R1 - Info bit 0 shows auto-init still running.
// R2 - Info bits 1 and 2 read zero.
// R3 - Bits 4:3 encode calibration pin self test.
// R4 - Self test updates only after calibration init.
// R5 - Pin tied to supply reports 01.
// R6 - Fault codes force factory trim, ignore calibration.
// R7 - Pass code proves connection, not resistor value.
// R8 - Burst length codes 4, 8, 16 only.
// R9 - Bit 3 picks sequential or interleaved order.
// R10 - Bit 4 picks no-wrap, four-beat only.
// R11 - Write recovery codes 1..6 mean 3..8.
// R12 - Wait recovery count before auto precharge.
// R13 - Four-beat wrap uses column bits 1:0.
// R14 - Eight-beat sequential mod 8 or XOR.
// R15 - Sixteen-beat sequential mod 16 only.
// R16 - No-wrap gives four consecutive columns.
// R17 - Column bit 0 always taken as zero.
// R18 - No-wrap starts only at permitted even columns.
// R19 - Registers reached only by mode commands.
// R20 - Reserved bits written and read as zero.
// R21 - Writes to info register change nothing.
// R22 - Reserved field codes keep previous setting.
//
// The implementer's own choice: the APB interface to the registers.
`include "mrb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mrb_device
    import mrb_pkg::*;
(
    mrb_link_if.device  link,
    input  wire logic   ce,
    input  wire logic   auto_init_busy_pin,
    input  wire logic   zq_tied_supply_pin,
    input  wire logic   zq_short_gnd_pin,
    output logic        factory_trim,
    output logic        calib_done,
    output logic        precharge_start
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            pin_meta <= 3'h7;
            pin_sync <= 3'h7;
        end else if (ce) begin
            pin_meta <= {auto_init_busy_pin, zq_tied_supply_pin, zq_short_gnd_pin};
            pin_sync <= pin_meta;
        end
    end

    // ----------------------------------------
    // Feature settings
    // ----------------------------------------
    logic [2:0] burst_length;
    logic       burst_order_type;
    logic       wrap_select;
    logic [2:0] write_recovery_cycles;
    logic [2:0] wd_bl;
    logic [2:0] wd_wr;
    logic       feat_wr;

    assign wd_bl   = link.mr_wdata[`MRB_BL_LSB +: 3];
    assign wd_wr   = link.mr_wdata[`MRB_WR_LSB +: 3];
    assign feat_wr = link.mr_valid && link.mr_write && link.mr_addr == `MRB_ADDR_FEAT; // see R19

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            burst_length          <= `MRB_BL_RST;
            burst_order_type      <= 1'b0;
            wrap_select           <= 1'b0;
            write_recovery_cycles <= `MRB_WR_RST;
        end else if (ce && feat_wr) begin
            if (wd_bl == `MRB_BL4 || wd_bl == `MRB_BL8 || wd_bl == `MRB_BL16) begin // see R8 see R22
                burst_length <= wd_bl;
            end
            burst_order_type <= link.mr_wdata[`MRB_BT_BIT]; // see R9
            wrap_select      <= link.mr_wdata[`MRB_WC_BIT]; // see R10
            if (wd_wr >= `MRB_WR_MIN && wd_wr <= `MRB_WR_MAX) begin // see R11 see R22
                write_recovery_cycles <= wd_wr;
            end
        end
    end

    // ----------------------------------------
    // Calibration self test
    // ----------------------------------------
    logic [1:0] calib_pin_selftest_result;
    logic [3:0] cal_cnt;
    logic       cal_run;
    logic       cal_fault;

    assign cal_fault = calib_pin_selftest_result == `MRB_ST_SUPPLY ||
                       calib_pin_selftest_result == `MRB_ST_GROUND;

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            calib_pin_selftest_result <= `MRB_ST_NOT_RUN;
            cal_cnt                   <= 4'h0;
            cal_run                   <= 1'b0;
            calib_done                <= 1'b0;
        end else if (ce) begin
            calib_done <= 1'b0;
            if (cal_run) begin
                cal_cnt <= cal_cnt - 4'h1;
                if (cal_cnt == 4'h1) begin
                    cal_run    <= 1'b0;
                    calib_done <= 1'b1;
                    if (pin_sync[1]) begin
                        calib_pin_selftest_result <= `MRB_ST_SUPPLY; // see R3 see R4 see R5
                    end else if (pin_sync[0]) begin
                        calib_pin_selftest_result <= `MRB_ST_GROUND; // see R3 see R4
                    end else begin
                        calib_pin_selftest_result <= `MRB_ST_PASS; // see R3 see R4 see R7
                    end
                end
            end else if (link.mr_valid && link.mr_write && link.mr_addr == `MRB_ADDR_CAL &&
                         link.mr_wdata == `MRB_CAL_INIT && !cal_fault) begin // see R6
                cal_run <= 1'b1;
                cal_cnt <= `MRB_CAL_CYCLES;
            end
        end
    end

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            factory_trim <= 1'b0;
        end else if (ce) begin
            factory_trim <= cal_fault; // see R6
        end
    end

    // ----------------------------------------
    // Mode register read
    // ----------------------------------------
    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            link.mr_rvalid <= 1'b0;
            link.mr_rdata  <= 8'h00;
        end else if (ce) begin
            link.mr_rvalid <= link.mr_valid && !link.mr_write; // see R19
            if (link.mr_valid && !link.mr_write) begin
                if (link.mr_addr == `MRB_ADDR_INFO) begin
                    // Writes to this address never reach any state. see R21
                    link.mr_rdata <= {3'h0, calib_pin_selftest_result, 1'b0, 1'b0, pin_sync[2]}; // see R1 see R2 see R20
                end else begin
                    link.mr_rdata <= 8'h00; // see R20
                end
            end
        end
    end

    // ----------------------------------------
    // Burst address engine
    // ----------------------------------------
    function automatic logic [3:0] beat_addr(
        input logic [2:0] bl,
        input logic       bt,
        input logic       wc,
        input logic [3:0] start,
        input logic [3:0] idx
    );
        logic [3:0] s;
        s = {start[3:1], 1'b0}; // see R17
        beat_addr = s + idx;    // see R15 see R16
        if (bl == `MRB_BL4 && !wc) begin
            beat_addr = {s[3:2], s[1:0] + idx[1:0]}; // see R13
        end else if (bl == `MRB_BL8) begin
            if (bt) begin
                beat_addr = {s[3], s[2:0] ^ idx[2:0]}; // see R14
            end else begin
                beat_addr = {s[3], s[2:0] + idx[2:0]}; // see R14
            end
        end
    endfunction

    mrb_dev_st_t state;
    logic [3:0]  beat_idx;
    logic [3:0]  last_idx;
    logic [3:0]  start_col;
    logic        write_ap;
    logic [3:0]  rec_cnt;

    always_comb begin
        last_idx = 4'h3;
        if (burst_length == `MRB_BL8) begin
            last_idx = 4'h7;
        end else if (burst_length == `MRB_BL16) begin
            last_idx = 4'hF;
        end
    end

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            state           <= DEV_IDLE;
            beat_idx        <= 4'h0;
            start_col       <= 4'h0;
            write_ap        <= 1'b0;
            rec_cnt         <= 4'h0;
            link.bst_busy   <= 1'b0;
            link.beat_valid <= 1'b0;
            link.beat_col   <= 4'h0;
            precharge_start <= 1'b0;
        end else if (ce) begin
            link.beat_valid <= 1'b0;
            precharge_start <= 1'b0;
            case (state)
                DEV_IDLE: begin
                    if (link.bst_start) begin
                        state         <= DEV_BURST;
                        start_col     <= link.bst_col;
                        write_ap      <= link.bst_write_ap;
                        beat_idx      <= 4'h0;
                        link.bst_busy <= 1'b1;
                    end
                end
                DEV_BURST: begin
                    link.beat_valid <= 1'b1;
                    link.beat_col   <= beat_addr(burst_length, burst_order_type, wrap_select,
                                                 start_col, beat_idx);
                    beat_idx        <= beat_idx + 4'h1;
                    if (beat_idx == last_idx) begin
                        if (write_ap) begin
                            state   <= DEV_RECOVER;
                            rec_cnt <= {1'b0, write_recovery_cycles} + `MRB_WR_BIAS; // see R12
                        end else begin
                            state         <= DEV_IDLE;
                            link.bst_busy <= 1'b0;
                        end
                    end
                end
                DEV_RECOVER: begin
                    rec_cnt <= rec_cnt - 4'h1;
                    if (rec_cnt == 4'h1) begin
                        state           <= DEV_IDLE;
                        precharge_start <= 1'b1; // see R12
                        link.bst_busy   <= 1'b0;
                    end
                end
                default: begin
                    state <= DEV_IDLE;
                end
            endcase
        end
    end

endmodule // mrb_device
`default_nettype wire

/* File: hdl/mrb_controller.sv */
`include "mrb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mrb_controller
    import mrb_pkg::*;
(
    mrb_link_if.controller  link,
    input  wire logic       ce,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic            pready,
    output logic [31:0]     prdata,
    output logic            pslverr
);

    // ----------------------------------------
    // Legality checks on the link
    // ----------------------------------------
    logic [2:0]  shadow_bl;
    logic        shadow_wc;
    logic        access;
    logic        wr_cmd;
    logic        wr_bst;
    logic        feat_ok;
    logic        col_ok;
    logic [2:0]  wbl;
    logic [2:0]  wwr;
    mrb_ctl_st_t state;
    logic        err;
    logic [7:0]  rd_data;

    assign access = psel && penable && !pready;
    assign wr_cmd = access && pwrite && paddr == `MRB_APB_CMD;
    assign wr_bst = access && pwrite && paddr == `MRB_APB_BURST;
    assign wbl    = pwdata[`MRB_BL_LSB +: 3];
    assign wwr    = pwdata[`MRB_WR_LSB +: 3];

    always_comb begin
        feat_ok = (wbl == `MRB_BL4 || wbl == `MRB_BL8 || wbl == `MRB_BL16) && // see R8
                  wwr >= `MRB_WR_MIN && wwr <= `MRB_WR_MAX &&                 // see R11
                  !(pwdata[`MRB_WC_BIT] && wbl != `MRB_BL4) &&                 // see R10
                  !(pwdata[`MRB_BT_BIT] && wbl == `MRB_BL16);                  // see R15
        if (!pwdata[16] || pwdata[15:8] != `MRB_ADDR_FEAT) begin
            feat_ok = 1'b1;
        end
        // No-wrap bursts start even and stay inside the 16-column span. see R16 see R18
        col_ok = !shadow_wc || (!pwdata[0] && pwdata[3:0] <= 4'hC);
    end

    // ----------------------------------------
    // Link requests
    // ----------------------------------------
    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            state             <= CTL_IDLE;
            err               <= 1'b0;
            rd_data           <= 8'h00;
            shadow_bl         <= `MRB_BL_RST;
            shadow_wc         <= 1'b0;
            link.mr_valid     <= 1'b0;
            link.mr_write     <= 1'b0;
            link.mr_addr      <= 8'h00;
            link.mr_wdata     <= 8'h00;
            link.bst_start    <= 1'b0;
            link.bst_col      <= 4'h0;
            link.bst_write_ap <= 1'b0;
        end else if (ce) begin
            link.mr_valid  <= 1'b0;
            link.bst_start <= 1'b0;
            case (state)
                CTL_IDLE: begin
                    if (wr_cmd) begin
                        if (!feat_ok || link.bst_busy) begin
                            err <= 1'b1;
                        end else begin
                            link.mr_valid <= 1'b1; // see R19
                            link.mr_write <= pwdata[16];
                            link.mr_addr  <= pwdata[15:8];
                            link.mr_wdata <= pwdata[7:0];
                            if (pwdata[16] && pwdata[15:8] == `MRB_ADDR_FEAT) begin
                                shadow_bl <= wbl;
                                shadow_wc <= pwdata[`MRB_WC_BIT];
                            end
                            if (!pwdata[16]) begin
                                state <= CTL_WAIT_READ;
                            end
                        end
                    end else if (wr_bst) begin
                        if (!col_ok || link.bst_busy) begin
                            err <= 1'b1;
                        end else begin
                            link.bst_start    <= 1'b1;
                            link.bst_col      <= {pwdata[3:1], 1'b0}; // see R18
                            link.bst_write_ap <= pwdata[4];
                        end
                    end else if (access && pwrite && paddr == `MRB_APB_STATUS) begin
                        err <= 1'b0;
                    end
                end
                CTL_WAIT_READ: begin
                    if (link.mr_rvalid) begin
                        rd_data <= link.mr_rdata; // see R20
                        state   <= CTL_IDLE;
                    end
                end
                default: begin
                    state <= CTL_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= access;
            pslverr <= access && paddr != `MRB_APB_CMD && paddr != `MRB_APB_STATUS &&
                       paddr != `MRB_APB_BURST;
            prdata  <= 32'h0000_0000;
            if (access && !pwrite && paddr == `MRB_APB_STATUS) begin
                prdata <= {16'h0000, rd_data, 4'h0, shadow_bl[0], link.bst_busy, err,
                           state != CTL_IDLE};
            end
        end
    end

endmodule // mrb_controller
`default_nettype wire

/* File: sim/mrb_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mrb_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       mr_valid,
    input wire logic       mr_write,
    input wire logic [7:0] mr_addr,
    input wire logic [7:0] mr_wdata,
    input wire logic       mr_rvalid,
    input wire logic [7:0] mr_rdata,
    input wire logic       bst_start,
    input wire logic [3:0] bst_col,
    input wire logic       bst_busy,
    input wire logic       beat_valid,
    input wire logic [3:0] beat_col
);
    logic [2:0] bl;
    logic       bt;
    logic       wc;
    logic [3:0] first;
    logic [3:0] idx;
    logic [3:0] exp_col;
    logic [3:0] col_mask;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Shadow of the burst setup
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bl <= 3'h2;
            bt <= 1'b0;
            wc <= 1'b0;
        end else if (mr_valid && mr_write && mr_addr == 8'h01) begin
            if (mr_wdata[2:0] >= 3'h2 && mr_wdata[2:0] <= 3'h4) begin
                bl <= mr_wdata[2:0];
            end
            bt <= mr_wdata[3];
            wc <= mr_wdata[4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first <= 4'h0;
            idx <= 4'h0;
        end else if (bst_start && !bst_busy) begin
            first <= {bst_col[3:1], 1'b0};
            idx <= 4'h0;
        end else if (beat_valid) begin
            idx <= idx + 4'h1;
        end
    end

    always_comb begin
        col_mask = (bl == 3'h4 || wc) ? 4'hF : (bl == 3'h3) ? 4'h7 : 4'h3;
        exp_col = (bl == 3'h3 && bt) ? (first ^ idx) : (first + idx);
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_read_answer: assert property (mr_valid && !mr_write |=> mr_rvalid)
        else $error("read answer missing");
    a_rvalid_cause: assert property (mr_rvalid |-> $past(mr_valid) && !$past(mr_write))
        else $error("read answer without request");
    a_info_reserved: assert property (mr_valid && !mr_write && mr_addr == 8'h00
        |=> mr_rdata[7:5] == 3'h0 && mr_rdata[2:1] == 2'h0)
        else $error("info reserved bits set");
    a_other_zero: assert property (mr_valid && !mr_write && mr_addr != 8'h00 |=> mr_rdata == 8'h00)
        else $error("other register not zero");
    a_feat_legal: assert property (mr_valid && mr_write && mr_addr == 8'h01
        |-> mr_wdata[2:0] >= 3'h2 && mr_wdata[2:0] <= 3'h4 && mr_wdata[7:5] != 3'h0
            && mr_wdata[7:5] != 3'h7 && (!mr_wdata[4] || mr_wdata[2:0] == 3'h2))
        else $error("illegal feature code sent");
    a_start_idle: assert property (bst_start |-> !bst_busy)
        else $error("burst start while busy");
    a_burst_launch: assert property (bst_start |=> bst_busy ##1 (beat_valid && !beat_col[0]))
        else $error("burst launch wrong");
    a_beat_order: assert property (beat_valid |-> ((beat_col ^ exp_col) & col_mask) == 4'h0)
        else $error("beat column out of order");
endmodule // mrb_chk
`default_nettype wire

/* File: sim/mode_reg_burst_order_test.sv */
`timescale 1ns/1ps
`default_nettype none
module mode_reg_burst_order_test;
    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        auto_init_busy_pin;
    logic        zq_tied_supply_pin;
    logic        zq_short_gnd_pin;
    logic        factory_trim;
    logic        calib_done;
    logic        precharge_start;
    logic [3:0]  beats[$];
    logic [31:0] q;
    logic [7:0]  v;
    logic        e;
    int          failures;
    int          comparisons;
    int          cyc;
    int          cal_pulses;
    int          last_beat;
    int          pre_at;
    int          c0;
    int          g1;

    mrb_link_if mrb_link_if_inst (.pclk(pclk), .presetn(presetn));
    mrb_device mrb_device_inst (.link(mrb_link_if_inst.device), .ce(ce), .auto_init_busy_pin(auto_init_busy_pin),
        .zq_tied_supply_pin(zq_tied_supply_pin), .zq_short_gnd_pin(zq_short_gnd_pin),
        .factory_trim(factory_trim), .calib_done(calib_done), .precharge_start(precharge_start));
    mrb_controller mrb_controller_inst (.link(mrb_link_if_inst.controller), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr));
    mrb_chk mrb_chk_inst (.pclk(pclk), .presetn(presetn), .mr_valid(mrb_link_if_inst.mr_valid),
        .mr_write(mrb_link_if_inst.mr_write), .mr_addr(mrb_link_if_inst.mr_addr),
        .mr_wdata(mrb_link_if_inst.mr_wdata), .mr_rvalid(mrb_link_if_inst.mr_rvalid),
        .mr_rdata(mrb_link_if_inst.mr_rdata), .bst_start(mrb_link_if_inst.bst_start),
        .bst_col(mrb_link_if_inst.bst_col), .bst_busy(mrb_link_if_inst.bst_busy),
        .beat_valid(mrb_link_if_inst.beat_valid), .beat_col(mrb_link_if_inst.beat_col));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Beats, calibration and precharge events as seen at each edge.
    always @(posedge pclk) begin
        cyc++;
        if (calib_done === 1'b1) cal_pulses++;
        if (precharge_start === 1'b1) pre_at = cyc;
        if (mrb_link_if_inst.beat_valid === 1'b1) begin
            beats.push_back(mrb_link_if_inst.beat_col);
            last_beat = cyc;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task timeout();
        failures++;
        $display("wait limit reached at %0t", $time);
        finish_test();
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) timeout();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task mr_write(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, 12'h000, {15'h0000, 1'b1, a, d});
    endtask

    task mr_read(input logic [7:0] a);
        int n;
        apb(1'b1, 12'h000, {15'h0000, 1'b0, a, 8'h00});
        n = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0000_0000);
            n++;
        end while (q[0] !== 1'b0 && n < 20);
        if (n >= 20) timeout();
        v = q[15:8];
    endtask

    task do_reset();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task burst(input logic [7:0] feat, input logic [3:0] col, input logic ap, input logic wr_feat);
        int n;
        int len;
        logic [3:0] m, s;
        if (wr_feat) mr_write(8'h01, feat);
        beats.delete();
        apb(1'b1, 12'h008, {27'h000_0000, ap, col});
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((n < 4 || mrb_link_if_inst.bst_busy !== 1'b0) && n < 60);
        if (n >= 60) timeout();
        @(posedge pclk);
        len = (feat[2:0] == 3'h2) ? 4 : (feat[2:0] == 3'h3) ? 8 : 16;
        m = (feat[2:0] == 3'h4 || feat[4]) ? 4'hF : (feat[2:0] == 3'h3) ? 4'h7 : 4'h3;
        s = {col[3:1], 1'b0};
        check(32'(beats.size()), 32'(len));
        for (int i = 0; i < len && i < beats.size(); i++) begin
            check(beats[i] & m, ((feat[2:0] == 3'h3 && feat[3]) ? s ^ i[3:0] : s + i[3:0]) & m);
        end
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        failures = 0;
        comparisons = 0;
        cyc = 0;
        cal_pulses = 0;
        last_beat = 0;
        pre_at = 0;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        auto_init_busy_pin = 1'b1;
        zq_tied_supply_pin = 1'b0;
        zq_short_gnd_pin = 1'b0;
        do_reset();
        mr_read(8'h00);
        check(v, 8'h01);
        auto_init_busy_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        mr_read(8'h00);
        check(v, 8'h00);
        mr_write(8'h00, 8'hFF);
        mr_read(8'h00);
        check(v, 8'h00);
        mr_read(8'h01);
        check(v, 8'h00);
        mr_read(8'h05);
        check(v, 8'h00);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check(e, 1'b1);
        $display("info test done");
        for (int k = 0; k < 3; k++) begin
            zq_tied_supply_pin <= (k == 0);
            zq_short_gnd_pin <= (k == 1);
            do_reset();
            mr_read(8'h00);
            check(v, 8'h00);
            c0 = cal_pulses;
            mr_write(8'h0A, 8'hFF);
            for (int n = 0; n < 30 && cal_pulses == c0; n++) @(posedge pclk);
            if (cal_pulses == c0) timeout();
            mr_read(8'h00);
            check(v, {3'h0, k[1:0] + 2'h1, 3'h0});
            check(factory_trim, k < 2);
            mr_write(8'h0A, 8'hFF);
            repeat (10) @(posedge pclk);
            check(32'(cal_pulses - c0), (k < 2) ? 32'h0000_0001 : 32'h0000_0002);
        end
        $display("calibration test done");
        burst(8'h22, 4'h2, 1'b0, 1'b0);
        burst(8'h32, 4'h4, 1'b0, 1'b1);
        burst(8'h23, 4'h6, 1'b0, 1'b1);
        burst(8'h2B, 4'h6, 1'b0, 1'b1);
        burst(8'h23, 4'h3, 1'b0, 1'b1);
        burst(8'h24, 4'hA, 1'b0, 1'b1);
        $display("burst order test done");
        burst(8'h22, 4'h0, 1'b1, 1'b1);
        g1 = pre_at - last_beat;
        check(32'(g1), 32'h0000_0003);
        burst(8'hC2, 4'h0, 1'b1, 1'b1);
        check(32'(pre_at - last_beat - g1), 32'h0000_0005);
        $display("recovery test done");
        mr_write(8'h01, 8'h27);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check({q[3], q[1]}, 2'h1);
        apb(1'b1, 12'h004, 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check(q[1], 1'b0);
        $display("refusal test done");
        finish_test();
    end
endmodule // mode_reg_burst_order_test
`default_nettype wire
